// ---- dv/afe_model.sv ----
// analog front end stand-in: hold capacitor, comparator, rc oscillator
`timescale 1ns/1ps
module afe_model (
	input wire sample_enable,
	input wire [9:0] dac_code,
	input wire [9:0] level,
	output wire cmp_in,
	output logic rc_osc
);
	logic [9:0] held = 10'h000;
	initial rc_osc = 1'b0;
	// free running, phase unrelated to the system clock
	always #40.5 rc_osc = ~rc_osc;
	always @(sample_enable or level) begin
		if (sample_enable)
			held = level;
	end
	assign cmp_in = held >= dac_code;
endmodule // afe_model

// ---- dv/sar_adc_checker_sva.sv ----
// port-level timing checker for the converter sequencer
`timescale 1ns/1ps
module sar_adc_checker (
	input wire clk,
	input wire rst_n,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	input wire converter_enable,
	input wire sample_enable,
	input wire [9:0] dac_code,
	input wire conversion_complete_flag
);
	reg [7:0] tcode;
	wire wr = psel && penable && pwrite && paddr == 8'h00;
	wire go_w = wr && pwdata[1:0] == 2'h3 && converter_enable;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// timing register has no port view, so track its writes
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			tcode <= 8'h00;
		else if (psel && penable && pwrite && paddr == 8'h04)
			tcode <= pwdata[7:0];
	end
	sequence s_conv_hold;
		!sample_enable throughout ##80 1'b1;
	endsequence
	sequence s_acq_hold;
		sample_enable [*8];
	endsequence
	AST_RST: assert property ($rose(rst_n) |-> !converter_enable && sample_enable &&
		!conversion_complete_flag) else $error("state after reset");
	AST_DONE: assert property ($rose(conversion_complete_flag) |-> $rose(sample_enable))
		else $error("completion without resample");
	AST_CONV_LEN: assert property ($fell(sample_enable) && tcode[2:0] == 3'h1 |->
		s_conv_hold ##[1:16] $rose(sample_enable)) else $error("conversion length");
	AST_ACQ: assert property (go_w && tcode[5:0] == 6'h14 |=> s_acq_hold ##[8:10]
		$fell(sample_enable)) else $error("acquisition length");
	AST_MANUAL: assert property (go_w && tcode[5:3] == 3'h0 && tcode[1:0] != 2'h3 |=>
		!sample_enable) else $error("manual start");
	AST_RC_DELAY: assert property (go_w && tcode[1:0] == 2'h3 |=> sample_enable [*4])
		else $error("rc start delay");
	AST_ABORT: assert property (wr && !pwdata[1] && !sample_enable |=> sample_enable &&
		!conversion_complete_flag) else $error("abort");
	AST_SAR_START: assert property ($fell(sample_enable) |-> ##[0:140]
		dac_code == 10'h200) else $error("first trial code");
endmodule // sar_adc_checker
bind sar_adc_sequencer sar_adc_checker sar_adc_checker_inst (.clk(clk), .rst_n(rst_n),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.converter_enable(converter_enable), .sample_enable(sample_enable), .dac_code(dac_code),
	.conversion_complete_flag(conversion_complete_flag));

// ---- dv/tb.sv ----
// self-checking bench of the converter sequencer
`timescale 1ns/1ps
module tb;
	logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, q, h;
	logic pready, pslverr, rc_osc, cmp_in, en, smp, flag, e;
	logic [9:0] dac, level = 10'h000;
	int bad_count = 0, comparisons = 0, an, cn;
	always #5 clk = ~clk;
	sar_adc_sequencer sar_adc_sequencer_inst (.clk(clk), .rst_n(rst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .rc_osc(rc_osc), .cmp_in(cmp_in),
		.converter_enable(en), .sample_enable(smp), .dac_code(dac),
		.conversion_complete_flag(flag));
	afe_model afe_model_inst (.sample_enable(smp), .dac_code(dac), .level(level),
		.cmp_in(cmp_in), .rc_osc(rc_osc));
	task give_verdict;
		if (bad_count == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task hang;
		bad_count++;
		give_verdict;
	endtask
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 50)
			hang;
	endtask
	task meas(input logic v, output int n);
		n = 0;
		#1;
		while (smp === v && n < 3000) begin
			@(posedge clk);
			#1;
			n++;
		end
		if (n >= 3000)
			hang;
	endtask
	task start(input logic [7:0] tm, input logic [9:0] lv);
		level <= lv;
		repeat (140) @(posedge clk);
		apb(1'b1, 8'h04, {24'h0, tm});
		apb(1'b1, 8'h00, 32'h1);
		apb(1'b1, 8'h10, 32'h0);
		apb(1'b1, 8'h00, 32'h3);
	endtask
	task conv(input logic [7:0] tm, input logic [9:0] lv);
		start(tm, lv);
		meas(1'b1, an);
		meas(1'b0, cn);
		chk({31'h0, flag}, 32'h1);
		apb(1'b0, 8'h00, 32'h0);
		chk(q, 32'h1);
		apb(1'b0, 8'h08, 32'h0);
		chk(q, tm[7] ? {30'h0, lv[9:8]} : {24'h0, lv[9:2]});
		apb(1'b0, 8'h0C, 32'h0);
		chk(q, tm[7] ? {24'h0, lv[7:0]} : {24'h0, lv[1:0], 6'h00});
	endtask
	task t_regs;
		apb(1'b0, 8'h00, 32'h0);
		chk(q, 32'h0);
		apb(1'b1, 8'h04, 32'hFF);
		apb(1'b0, 8'h04, 32'h0);
		chk(q, 32'hBF);
		apb(1'b0, 8'h14, 32'h0);
		chk({31'h0, e}, 32'h1);
		chk(q, 32'h0);
	endtask
	task t_clk_codes;
		int d[8] = '{2, 8, 32, 0, 4, 16, 64, 0};
		for (int c = 0; c < 8; c++) begin
			conv({c[0], 4'h0, c[2:0]}, 10'h3FF - 10'(c * 146));
			if (c[1:0] == 2'h3)
				chk({31'h0, cn >= 80 && cn <= 92}, 32'h1);
			else
				chk({31'h0, cn >= 11 * d[c] - 1 && cn <= 12 * d[c] + 3}, 32'h1);
			chk(an, (c[1:0] == 2'h3) ? 32'h4 : 32'h0);
		end
	endtask
	task t_acq_codes;
		int t[8] = '{0, 2, 4, 6, 8, 12, 16, 20};
		for (int a = 0; a < 8; a++) begin
			conv({a[0], 1'b0, a[2:0], 3'h4}, 10'h155 + 10'(a));
			chk(an, 4 * t[a]);
		end
	endtask
	task t_abort_reset;
		apb(1'b0, 8'h08, 32'h0);
		h = q;
		start(8'h85, 10'h0AA);
		repeat (20) @(posedge clk);
		apb(1'b1, 8'h00, 32'h1);
		#1;
		chk({30'h0, smp, flag}, 32'h2);
		apb(1'b0, 8'h08, 32'h0);
		chk(q, h);
		start(8'h86, 10'h2F0);
		repeat (30) @(posedge clk);
		rst_n <= 1'b0;
		repeat (3) @(posedge clk);
		#1;
		chk({29'h0, en, smp, flag}, 32'h2);
		@(posedge clk);
		rst_n <= 1'b1;
		apb(1'b0, 8'h08, 32'h0);
		chk(q, h);
		apb(1'b0, 8'h04, 32'h0);
		chk(q, 32'h0);
	endtask
	initial begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		t_regs;
		t_clk_codes;
		t_acq_codes;
		t_abort_reset;
		give_verdict;
	end
endmodule // tb

// ---- logic/sar_adc_consts.vh ----
// register map, field positions, reset values and timing counts of the converter sequencer
`ifndef SAR_ADC_CONSTS_VH
`define SAR_ADC_CONSTS_VH

`define MAIN_CTRL_OFFSET 8'h00
`define TIMING_CTRL_OFFSET 8'h04
`define RESULT_HIGH_OFFSET 8'h08
`define RESULT_LOW_OFFSET 8'h0C
`define STATUS_OFFSET 8'h10

`define MAIN_ENABLE_BIT 0
`define MAIN_GO_BIT 1
`define FORMAT_BIT 7
`define ACQ_MSB 5
`define ACQ_LSB 3
`define CLK_MSB 2
`define CLK_LSB 0
`define STATUS_DONE_BIT 0

`define MAIN_CTRL_RESET 2'h0
`define TIMING_CTRL_RESET 8'h00

`define CLK_PERIOD_NS 10
`define INSN_CYCLE_NS 40
`define INSN_CYCLE_CLKS ((`INSN_CYCLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CONV_TADS 11

`endif

// ---- logic/sar_adc_sequencer.v ----
// successive-approximation converter sequencer with its APB register file
//
// Contract
// - result right justified when format bit is 1, left when 0
// - acquisition field maps to 20,16,12,8,6,4,2,0 conversion-clock periods
// - clock field picks system/2,8,32,4,16,64 or the internal RC oscillator
// - RC clock selected: one instruction cycle delay before conversion clock starts
// - reset restores registers, turns converter off, aborts any conversion
// - on completion load result, clear go, set completion flag
// - result pair is not touched by reset
// - nonzero acquisition code: sample programmed period then convert automatically
// - acquisition code 000: go stops sampling and starts conversion at once
// - acquisition field resets to 000
// - after each conversion sampling of the selected channel resumes
// - only go is visible; acquisition end versus conversion start is hidden
// - result comes from successive approximation of the held sample
// - conversion start disconnects the holding capacitor from the input
// - one ten-bit conversion takes eleven conversion-clock periods
// - clearing go mid-conversion aborts it, result pair left unchanged
// - go sits at main control bit 1, reads 1 while converting
//
// Design decisions made here: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`include "sar_adc_consts.vh"

module sar_adc_sequencer #(
	parameter INSN_CLKS = `INSN_CYCLE_CLKS
) (
	input wire clk,
	input wire rst_n,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	input wire rc_osc,
	input wire cmp_in,
	output reg converter_enable,
	output reg sample_enable,
	output reg [9:0] dac_code,
	output reg conversion_complete_flag
);

	localparam ST_IDLE = 2'd0;
	localparam ST_DELAY = 2'd1;
	localparam ST_ACQ = 2'd2;
	localparam ST_CONV = 2'd3;

	reg [1:0] state;
	reg go;
	reg [7:0] timing;
	reg [7:0] result_high;
	reg [7:0] result_low;
	reg [5:0] div_cnt;
	reg [4:0] acq_cnt;
	reg [3:0] tad_cnt;
	reg [2:0] dly_cnt;
	reg rc_meta;
	reg rc_sync;
	reg rc_last;
	reg cmp_meta;
	reg cmp_sync;

	wire [2:0] acq_code = timing[`ACQ_MSB:`ACQ_LSB];
	wire [2:0] clk_code = timing[`CLK_MSB:`CLK_LSB];
	wire use_rc = (clk_code[1:0] == 2'b11);
	wire wr = psel & penable & pwrite;
	wire setup = psel & ~penable;
	wire addr_ok = (paddr == `MAIN_CTRL_OFFSET) | (paddr == `TIMING_CTRL_OFFSET) |
		(paddr == `RESULT_HIGH_OFFSET) | (paddr == `RESULT_LOW_OFFSET) |
		(paddr == `STATUS_OFFSET);
	wire wr_main = wr & (paddr == `MAIN_CTRL_OFFSET);
	wire wr_timing = wr & (paddr == `TIMING_CTRL_OFFSET);
	wire wr_status = wr & (paddr == `STATUS_OFFSET);
	wire wr_go = pwdata[`MAIN_GO_BIT];

	// zero wait states, so pready can be tied high
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~addr_ok;

	// conversion clock period in system clocks; RC codes never use it
	function [5:0] div_len;
		input [2:0] code;
		begin
			case (code)
			3'b000: div_len = 6'd2;
			3'b001: div_len = 6'd8;
			3'b010: div_len = 6'd32;
			3'b100: div_len = 6'd4;
			3'b101: div_len = 6'd16;
			3'b110: div_len = 6'd63;
			default: div_len = 6'd2;
			endcase
		end
	endfunction

	// acquisition length in conversion-clock periods; 000 never enters acquisition
	function [4:0] acq_len;
		input [2:0] code;
		begin
			case (code)
			3'b111: acq_len = 5'd20;
			3'b110: acq_len = 5'd16;
			3'b101: acq_len = 5'd12;
			3'b100: acq_len = 5'd8;
			3'b011: acq_len = 5'd6;
			3'b010: acq_len = 5'd4;
			3'b001: acq_len = 5'd2;
			default: acq_len = 5'd0;
			endcase
		end
	endfunction

	// /64 needs 64 counts; a 6-bit counter wraps after 63 so that code adds one
	wire [6:0] div_full = (clk_code == 3'b110) ? 7'd64 : {1'b0, div_len(clk_code)};
	wire div_tick = ({1'b0, div_cnt} == div_full - 7'd1);
	wire rc_tick = rc_sync & ~rc_last;
	wire tad_tick = use_rc ? rc_tick : div_tick;
	wire abort = (state != ST_IDLE) & (wr_main & (~wr_go | ~pwdata[`MAIN_ENABLE_BIT]));
	// a clear of go in the completing period still aborts: no result, no flag
	wire conv_done = (state == ST_CONV) & tad_tick & (tad_cnt == `CONV_TADS - 1) &
		~abort;
	// go in the same write that powers the converter up is refused
	wire start = (state == ST_IDLE) & wr_main & wr_go & converter_enable &
		pwdata[`MAIN_ENABLE_BIT];
	wire [9:0] trial_bit = 10'h200 >> tad_cnt;
	// period k decides bit 10-k; eleven bits wide so the last period still reaches bit 0
	wire [10:0] prev_wide = 11'h400 >> tad_cnt;
	wire [9:0] prev_bit = prev_wide[9:0];
	// keep the pending trial bit only if the held sample is at or above it
	wire [9:0] next_code = cmp_sync ? dac_code : (dac_code & ~prev_bit);

	// limitation: a comparator answer needs three clocks to be seen, so at /2
	// each decision sees the previous trial; use /4 or slower for exact results
	// pins from outside: two flops before any logic looks at them
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rc_meta <= 1'b0;
			rc_sync <= 1'b0;
			rc_last <= 1'b0;
			cmp_meta <= 1'b0;
			cmp_sync <= 1'b0;
		end else begin
			rc_meta <= rc_osc;
			rc_sync <= rc_meta;
			rc_last <= rc_sync;
			cmp_meta <= cmp_in;
			cmp_sync <= cmp_meta;
		end
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			converter_enable <= 1'b0;
			timing <= `TIMING_CTRL_RESET;
		end else begin
			if (wr_main)
				converter_enable <= pwdata[`MAIN_ENABLE_BIT];
			// bit 6 is not implemented and always reads 0
			if (wr_timing)
				timing <= pwdata[7:0] & 8'hBF;
		end
	end

	// sequencer; reset aborts whatever is running
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= ST_IDLE;
			go <= 1'b0;
			sample_enable <= 1'b1;
			div_cnt <= 6'h00;
			acq_cnt <= 5'h00;
			tad_cnt <= 4'h0;
			dly_cnt <= 3'h0;
			dac_code <= 10'h000;
		end else begin
			// divider restarts with every phase so its first period is full length
			if (state == ST_IDLE || state == ST_DELAY || tad_tick)
				div_cnt <= 6'h00;
			else
				div_cnt <= div_cnt + 6'h01;
			// sampling resumes after an abort just as after a completion
			if (abort) begin
				state <= ST_IDLE;
				go <= 1'b0;
				sample_enable <= 1'b1;
			end else begin
				case (state)
				ST_IDLE: begin
					sample_enable <= 1'b1;
					// go is decoded only here, so a second go while busy is ignored
					if (start) begin
						go <= 1'b1;
						dly_cnt <= 3'h0;
						acq_cnt <= 5'h00;
						tad_cnt <= 4'h0;
						if (use_rc) begin
							state <= ST_DELAY;
						end else if (acq_code == 3'b000) begin
							state <= ST_CONV;
							sample_enable <= 1'b0;
						end else begin
							state <= ST_ACQ;
						end
					end
				end
				ST_DELAY: begin
					// lets a sleep instruction run before the conversion clock starts
					dly_cnt <= dly_cnt + 3'h1;
					if ({29'h0, dly_cnt} == INSN_CLKS - 1) begin
						if (acq_code == 3'b000) begin
							state <= ST_CONV;
							sample_enable <= 1'b0;
						end else begin
							state <= ST_ACQ;
						end
					end
				end
				ST_ACQ: begin
					if (tad_tick) begin
						acq_cnt <= acq_cnt + 5'h01;
						if (acq_cnt == acq_len(acq_code) - 5'd1) begin
							state <= ST_CONV;
							sample_enable <= 1'b0;
						end
					end
				end
				ST_CONV: begin
					if (tad_tick) begin
						tad_cnt <= tad_cnt + 4'h1;
						// first period holds the sample, then one bit per period
						if (tad_cnt == 4'h0)
							dac_code <= 10'h200;
						else
							dac_code <= next_code | trial_bit;
						if (conv_done) begin
							state <= ST_IDLE;
							go <= 1'b0;
							sample_enable <= 1'b1;
						end
					end
				end
				default: state <= ST_IDLE;
				endcase
			end
		end
	end

	// final bit decided in the completing period
	wire [9:0] final_code = cmp_sync ? dac_code : (dac_code & 10'h3FE);

	// result pair has no reset so its content survives a device reset
	// a completion overrides a same-cycle software write of the pair
	always @(posedge clk) begin
		if (conv_done) begin
			if (timing[`FORMAT_BIT]) begin
				result_high <= {6'h00, final_code[9:8]};
				result_low <= final_code[7:0];
			end else begin
				result_high <= final_code[9:2];
				result_low <= {final_code[1:0], 6'h00};
			end
		end else begin
			if (wr & (paddr == `RESULT_HIGH_OFFSET))
				result_high <= pwdata[7:0];
			if (wr & (paddr == `RESULT_LOW_OFFSET))
				result_low <= pwdata[7:0];
		end
	end

	// completion flag: hardware set wins over software clear
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			conversion_complete_flag <= 1'b0;
		else if (conv_done)
			conversion_complete_flag <= 1'b1;
		else if (wr_status & ~pwdata[`STATUS_DONE_BIT])
			conversion_complete_flag <= 1'b0;
	end

	// read data captured in the setup cycle, valid through the access cycle
	// unmapped reads return zero alongside the error response
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prdata <= 32'h00000000;
		end else if (setup & ~pwrite) begin
			case (paddr)
			`MAIN_CTRL_OFFSET: prdata <= {30'h0, go, converter_enable};
			`TIMING_CTRL_OFFSET: prdata <= {24'h0, timing};
			`RESULT_HIGH_OFFSET: prdata <= {24'h0, result_high};
			`RESULT_LOW_OFFSET: prdata <= {24'h0, result_low};
			`STATUS_OFFSET: prdata <= {31'h0, conversion_complete_flag};
			default: prdata <= 32'h00000000;
			endcase
		end
	end

endmodule // sar_adc_sequencer
